// ### src/pie_top.sv
// Peripheral interrupt enable mask with its companion flag register.
// Assumes an AXI4-Lite master; event pulses come from the core clock domain.
//
// Notes on behaviour
// - Enable bits 7 and 6 reserved, read zero
// - Bit 5 enables serial receive interrupt
// - Bit 4 enables serial transmit interrupt
// - Bit 3 enables sync serial port interrupt
// - Bit 2 enables capture/compare one interrupt
// - Bit 1 enables timer two match interrupt
// - Bit 0 enables timer one overflow interrupt
// - Enable bits 5 to 0 read/write, all enable bits reset zero
// - Flag bits 7 and 6 never set
// - Sync port flag at flag bit three
`timescale 1ns/1ps
module pie_top (
   input  wire logic                     clock,
   input  wire logic                     reset_n,
   input  wire pie_pkg::pie_axi_req_type axi_req,
   output pie_pkg::pie_axi_rsp_type      axi_rsp,
   input  wire logic [5:0]               event_pulse,
   output logic [7:0]                    peripheral_interrupt_enable,
   output logic [7:0]                    peripheral_interrupt_flags,
   output logic                          peripheral_irq
);
   // ********************************************************
   // State
   // ********************************************************
   typedef struct packed {
      logic [7:0]  enable;
      logic [7:0]  flags;
      logic        aw_held;
      logic [3:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pie_state_type;

   pie_state_type state_q;
   pie_state_type state_d;
   logic [5:0]    source_req;
   logic [7:0]    wmask;
   logic          do_write;
   logic          flags_wr;

   // ********************************************************
   // Request gating
   // ********************************************************
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gen_src
         pie_mask_bit u_bit (
            .flag    (state_q.flags[g]),
            .enable  (state_q.enable[g]),
            .request (source_req[g])
         );
      end
   endgenerate

   assign peripheral_irq              = |source_req;
   assign peripheral_interrupt_enable = state_q.enable;
   assign peripheral_interrupt_flags  = state_q.flags;

   assign axi_rsp.awready = ~state_q.aw_held & ~state_q.bvalid;
   assign axi_rsp.wready  = ~state_q.w_held & ~state_q.bvalid;
   assign axi_rsp.bvalid  = state_q.bvalid;
   assign axi_rsp.bresp   = state_q.bresp;
   assign axi_rsp.arready = ~state_q.rvalid;
   assign axi_rsp.rvalid  = state_q.rvalid;
   assign axi_rsp.rdata   = state_q.rdata;
   assign axi_rsp.rresp   = state_q.rresp;

   // ********************************************************
   // Next state
   // ********************************************************
   always_comb begin
      state_d  = state_q;
      wmask    = 8'h00;
      do_write = 1'h0;
      flags_wr = 1'h0;
      if (axi_req.awvalid && axi_rsp.awready) begin
         state_d.aw_held = 1'h1;
         state_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         state_d.w_held = 1'h1;
         state_d.w_data = axi_req.wdata;
         state_d.w_strb = axi_req.wstrb;
      end
      if (state_q.aw_held && state_q.w_held) begin
         do_write        = 1'h1;
         wmask           = state_q.w_strb[0] ? pie_pkg::LIVE_MASK : 8'h00;
         state_d.aw_held = 1'h0;
         state_d.w_held  = 1'h0;
         state_d.bvalid  = 1'h1;
         state_d.bresp   = pie_pkg::RESP_OKAY;
         case (state_q.aw_addr)
            pie_pkg::ENABLE_OFFSET: begin
               // Only the enable changes here
               state_d.enable = (state_q.enable & ~wmask) | (state_q.w_data[7:0] & wmask);
            end
            pie_pkg::FLAGS_OFFSET: begin
               flags_wr = 1'h1;
            end
            pie_pkg::REQ_OFFSET: begin
               state_d.bresp = pie_pkg::RESP_OKAY;
            end
            default: begin
               state_d.bresp = pie_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Software writes the flags; events win over clears
      if (flags_wr) begin
         state_d.flags = (state_q.flags & ~wmask) | (state_q.w_data[7:0] & wmask);
      end
      state_d.flags = (state_d.flags | {2'h0, event_pulse}) & pie_pkg::LIVE_MASK;
      if (state_q.bvalid && axi_req.bready) begin
         state_d.bvalid = 1'h0;
      end
      if (state_q.rvalid && axi_req.rready) begin
         state_d.rvalid = 1'h0;
      end
      if (axi_req.arvalid && axi_rsp.arready) begin
         state_d.rvalid = 1'h1;
         state_d.rresp  = pie_pkg::RESP_OKAY;
         state_d.rdata  = 32'h0000_0000;
         case (axi_req.araddr)
            pie_pkg::ENABLE_OFFSET: state_d.rdata[7:0] = state_q.enable;
            pie_pkg::FLAGS_OFFSET:  state_d.rdata[7:0] = state_q.flags;
            pie_pkg::REQ_OFFSET:    state_d.rdata[0]   = peripheral_irq;
            default:                state_d.rresp      = pie_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q        <= '0;
         state_q.enable <= pie_pkg::ENABLE_RESET;
         state_q.flags  <= pie_pkg::FLAGS_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ********************************************************
   // Checks
   // ********************************************************
   reserved_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
      state_q.enable[7:6] == 2'h0) else $error("reserved enable bits set");
   reserved_flags_a: assert property (@(posedge clock) disable iff (!reset_n)
      state_q.flags[7:6] == 2'h0) else $error("reserved flag bits set");
   request_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      peripheral_irq == |(state_q.flags[5:0] & state_q.enable[5:0]))
      else $error("request not flag and enable");
   sync_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      event_pulse[pie_pkg::SYNC_BIT] |=> state_q.flags[pie_pkg::SYNC_BIT])
      else $error("sync port flag lost");
   rx_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q.flags[pie_pkg::RX_BIT] && !state_q.enable[pie_pkg::RX_BIT]
       && state_q.flags[4:0] == 5'h00) |-> !peripheral_irq) else $error("rx not masked");
   tx_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q.flags[pie_pkg::TX_BIT] && state_q.enable[pie_pkg::TX_BIT]) |-> peripheral_irq)
      else $error("tx request missing");
   enable_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      (do_write && state_q.aw_addr == pie_pkg::ENABLE_OFFSET && state_q.w_strb[0])
      |=> state_q.enable == ($past(state_q.w_data[7:0]) & pie_pkg::LIVE_MASK))
      else $error("enable write lost");
   flags_kept_a: assert property (@(posedge clock) disable iff (!reset_n)
      (do_write && state_q.aw_addr == pie_pkg::ENABLE_OFFSET)
      |=> state_q.flags == ($past(state_q.flags) | $past({2'h0, event_pulse})))
      else $error("enable write altered flags");
   reset_clear_a: assert property (@(posedge clock)
      !reset_n |=> state_q.enable == 8'h00) else $error("enable not cleared by reset");
   flags_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      (do_write && state_q.aw_addr == pie_pkg::FLAGS_OFFSET && state_q.w_strb[0] && event_pulse == 6'h00)
      |=> state_q.flags == ($past(state_q.w_data[7:0]) & pie_pkg::LIVE_MASK))
      else $error("flag write lost");

   // ********************************************************
   // Bus handshake checks
   // ********************************************************
   // Write steps: both halves held, then response
   sequence write_commit_s;
      state_q.aw_held && state_q.w_held;
   endsequence

   sequence write_answer_s;
      axi_rsp.bvalid && !axi_rsp.awready && !axi_rsp.wready;
   endsequence

   // Read steps: address taken, then data
   sequence read_accept_s;
      axi_req.arvalid && axi_rsp.arready;
   endsequence

   sequence read_answer_s;
      axi_rsp.rvalid && !axi_rsp.arready;
   endsequence

   write_answer_a: assert property (@(posedge clock) disable iff (!reset_n)
      write_commit_s |=> write_answer_s) else $error("write not answered");
   read_answer_a: assert property (@(posedge clock) disable iff (!reset_n)
      read_accept_s |=> read_answer_s) else $error("read not answered");
   bvalid_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(axi_rsp.bvalid) |-> $past(axi_req.bready))
      else $error("write response dropped early");
   rvalid_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(axi_rsp.rvalid) |-> $past(axi_req.rready))
      else $error("read data dropped early");
   enable_read_a: assert property (@(posedge clock) disable iff (!reset_n)
      (read_accept_s ##0 (axi_req.araddr == pie_pkg::ENABLE_OFFSET))
      |=> axi_rsp.rdata == {24'h000000, $past(state_q.enable)}) else $error("enable read wrong");
endmodule

// ### src/pie_pkg.sv
// Package for the peripheral interrupt enable mask block.
// Assumes an AXI4-Lite master with 32-bit data on the core clock.
package pie_pkg;
   // ********************************************************
   // Register map
   // ********************************************************
   localparam logic [3:0] ENABLE_OFFSET = 4'h0;
   localparam logic [3:0] FLAGS_OFFSET  = 4'h4;
   localparam logic [3:0] REQ_OFFSET    = 4'h8;
   localparam logic [7:0] ENABLE_RESET  = 8'h00;
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] LIVE_MASK     = 8'h3f;
   localparam int         RX_BIT        = 5;
   localparam int         TX_BIT        = 4;
   localparam int         SYNC_BIT      = 3;
   localparam int         CAPCOMP_BIT   = 2;
   localparam int         TIMER2_BIT    = 1;
   localparam int         TIMER1_BIT    = 0;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [3:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [3:0]  araddr;
      logic        arvalid;
      logic        rready;
   } pie_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } pie_axi_rsp_type;
endpackage

// ### src/pie_mask_bit.sv
// One source: gates a flag with its enable.
// Assumes flag and enable on the core clock.
`timescale 1ns/1ps
module pie_mask_bit (
   input  wire logic flag,
   input  wire logic enable,
   output logic      request
);
   assign request = flag & enable;
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the interrupt enable mask block.
// Assumes pie_top with an AXI4-Lite slave on one 20 MHz clock.
`timescale 1ns/1ps
module tb_top;
   logic                     clock;
   logic                     reset_n;
   pie_pkg::pie_axi_req_type req;
   pie_pkg::pie_axi_rsp_type rsp;
   logic [5:0]               ev;
   logic [7:0]               en_o;
   logic [7:0]               fl_o;
   logic                     irq;
   int                       mismatches;
   int                       total_checks;
   logic [31:0]              rd;
   logic [3:0]               strb;
   logic [14:0]              rows [9];

   pie_top i_dut (.clock(clock), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp), .event_pulse(ev),
      .peripheral_interrupt_enable(en_o), .peripheral_interrupt_flags(fl_o), .peripheral_irq(irq));

   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end

   // ********
   // Tasks
   // ********
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 60) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock);
      req.awaddr  <= a;
      req.wdata   <= {24'h0, d};
      req.wstrb   <= strb;
      req.awvalid <= 1'h1;
      req.wvalid  <= 1'h1;
      req.bready  <= 1'h1;
      do begin
         @(posedge clock);
         n++;
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'h0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'h0;
      end while (rsp.bvalid !== 1'h1 && n < 60);
      req.bready <= 1'h0;
      tmo(n);
      chk({30'h0, rsp.bresp}, {30'h0, er});
   endtask

   task automatic rdr(input logic [3:0] a, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock);
      req.araddr  <= a;
      req.arvalid <= 1'h1;
      req.rready  <= 1'h1;
      do begin
         @(posedge clock);
         n++;
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'h0;
      end while (rsp.rvalid !== 1'h1 && n < 60);
      req.rready <= 1'h0;
      rd = rsp.rdata;
      tmo(n);
      chk({30'h0, rsp.rresp}, {30'h0, er});
   endtask

   // ********
   // Sequence
   // ********
   initial begin
      req = '0;
      ev = 6'h0;
      strb = 4'h1;
      reset_n = 1'h0;
      mismatches = 0;
      total_checks = 0;
      rows = '{{8'hff, 6'h00, 1'h0}, {8'h20, 6'h20, 1'h1}, {8'h10, 6'h10, 1'h1}, {8'h08, 6'h08, 1'h1},
               {8'h04, 6'h04, 1'h1}, {8'h02, 6'h02, 1'h1}, {8'h01, 6'h01, 1'h1}, {8'h1f, 6'h20, 1'h0},
               {8'hc0, 6'h3f, 1'h0}};
      repeat (2) @(posedge clock);
      reset_n <= 1'h1;
      rdr(pie_pkg::ENABLE_OFFSET, pie_pkg::RESP_OKAY);
      chk(rd, 32'h0);
      chk({23'h0, fl_o, irq}, 32'h0);
      foreach (rows[i]) begin
         wr(pie_pkg::FLAGS_OFFSET, 8'h00, pie_pkg::RESP_OKAY);
         wr(pie_pkg::ENABLE_OFFSET, rows[i][14:7], pie_pkg::RESP_OKAY);
         @(posedge clock);
         ev <= rows[i][6:1];
         @(posedge clock);
         ev <= 6'h0;
         rdr(pie_pkg::ENABLE_OFFSET, pie_pkg::RESP_OKAY);
         chk(rd, {24'h0, rows[i][14:7] & 8'h3f});
         chk({24'h0, fl_o}, {26'h0, rows[i][6:1]});
         chk({31'h0, irq}, {31'h0, rows[i][0]});
         $display("row %0d done", i);
      end
      wr(4'hc, 8'h3f, pie_pkg::RESP_SLVERR);
      rdr(4'hc, pie_pkg::RESP_SLVERR);
      chk(rd, 32'h0);
      chk({24'h0, en_o}, 32'h0);
      wr(pie_pkg::ENABLE_OFFSET, 8'h08, pie_pkg::RESP_OKAY);
      chk({23'h0, fl_o, irq}, 32'h7f);
      wr(pie_pkg::REQ_OFFSET, 8'h00, pie_pkg::RESP_OKAY);
      rdr(pie_pkg::REQ_OFFSET, pie_pkg::RESP_OKAY);
      chk(rd, 32'h1);
      wr(pie_pkg::ENABLE_OFFSET, 8'h00, pie_pkg::RESP_OKAY);
      rdr(pie_pkg::REQ_OFFSET, pie_pkg::RESP_OKAY);
      chk({23'h0, fl_o, rd[0]}, 32'h7e);
      $display("mask and bus tests done");
      strb = 4'h0;
      wr(pie_pkg::ENABLE_OFFSET, 8'h3f, pie_pkg::RESP_OKAY);
      strb = 4'h1;
      chk({24'h0, en_o}, 32'h0);
      ev <= 6'h08;
      wr(pie_pkg::FLAGS_OFFSET, 8'h00, pie_pkg::RESP_OKAY);
      ev <= 6'h00;
      chk({24'h0, fl_o}, 32'h08);
      $display("strobe and event priority done");
      reset_n <= 1'h0;
      repeat (2) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      chk({15'h0, en_o, fl_o, irq}, 32'h0);
      $display("second reset done");
      report_and_stop();
   end
endmodule
